/* File: brmd_top.sv */
// Notes on behaviour
// - Strap high: byte on low lane when A0 low, high lane when A0 high.
// - Strap low: byte on high lane when A0 low, low lane when A0 high.
// - Strap 0 picks big-endian-style map, strap 1 little-endian-style map.
// - Each register decodes at its map-dependent offset, e.g. mode 18 or 1B.
// - One copy of each global register, reachable whatever channel is active.
// - Two copies of each per-channel register; only active channel's copy reached.
// - Channel select value holds until the host writes it again.
// - During interrupt or DMA service the device supplies the channel number.
// - Some offsets alias to async or sync functions by protocol mode.
// - Word transfers: earlier byte low lane with strap high, else high lane.
`timescale 1ns/1ns
module brmd_top (
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   input wire logic byte_order_in,
   input wire logic acc_req_in,
   input wire logic acc_wr_in,
   input wire logic acc_word_in,
   input wire logic [7:0] acc_addr_in,
   input wire logic [15:0] acc_wdata_in,
   input wire logic svc_active_in,
   input wire logic svc_chan_in,
   output logic ack_out,
   output logic [15:0] rdata_out,
   output logic map_le_out,
   output logic active_chan_out,
   output logic sync_mode_out
);
   brmd_bank_if bank ();

   logic strap_q;
   logic [7:0] car_q;
   logic [7:0] firmware_revision_code_q;
   logic [7:0] cmr_q [2];
   logic chan;
   logic sync;
   logic car_wr;
   logic firmware_revision_code_wr;
   logic [7:0] byte_addr [brmd_pkg::NUM_PORTS];
   logic port_en [brmd_pkg::NUM_PORTS];
   logic lane_hi [brmd_pkg::NUM_PORTS];
   logic [7:0] wd_p [brmd_pkg::NUM_PORTS];
   logic [5:0] look [brmd_pkg::NUM_PORTS];
   brmd_pkg::brmd_src_t kind [brmd_pkg::NUM_PORTS];
   logic rd_a_q;
   logic ack_a_q;
   logic en_a_q [brmd_pkg::NUM_PORTS];
   logic hi_a_q [brmd_pkg::NUM_PORTS];
   brmd_pkg::brmd_src_t src_a_q [brmd_pkg::NUM_PORTS];
   logic [7:0] glob_a_q [brmd_pkg::NUM_PORTS];
   logic [15:0] rdata_d;
   logic [15:0] rdata_q;
   logic ack_q;

   // Per-channel decode; mode picks which alias of a shared offset answers
   function automatic logic [5:0] slot_lookup(
      input logic [7:0] a,
      input logic le,
      input logic sy
   );
      logic [5:0] r;
      logic [7:0] ofs;
      logic skip;
      r = 6'h00;
      for (int i = 0; i < brmd_pkg::NUM_SLOTS; i++) begin
         ofs = le ? brmd_pkg::SLOT_OFS_LE[i] : brmd_pkg::SLOT_OFS_BE[i];
         skip = sy ? (i >= brmd_pkg::ASYNC_FIRST && i <= brmd_pkg::ASYNC_LAST)
                   : (i >= brmd_pkg::SYNC_FIRST && i <= brmd_pkg::SYNC_LAST);
         if (ofs == a && !skip) begin
            r = {1'b1, 5'(i)};
         end
      end
      return r;
   endfunction

   // Global decode, shared by both byte ports
   function automatic brmd_pkg::brmd_src_t glob_lookup(
      input logic [7:0] a,
      input logic le
   );
      brmd_pkg::brmd_src_t s;
      s = brmd_pkg::SRC_NONE;
      if (a == (le ? brmd_pkg::OFS_FIRMWARE_REVISION_CODE_LE : brmd_pkg::OFS_FIRMWARE_REVISION_CODE_BE)) begin
         s = brmd_pkg::SRC_FIRMWARE_REVISION_CODE;
      end
      if (a == (le ? brmd_pkg::OFS_CAR_LE : brmd_pkg::OFS_CAR_BE)) begin
         s = brmd_pkg::SRC_CAR;
      end
      return s;
   endfunction

   // strap captured
   // Sampled only in reset; later pin changes are ignored so the map never moves
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         strap_q <= byte_order_in;
      end
   end

   assign chan = svc_active_in ? svc_chan_in : car_q[brmd_pkg::CAR_CHAN_BIT];
   assign sync = cmr_q[chan][brmd_pkg::CMR_SYNC_BIT];

   genvar gp;
   generate
      for (gp = 0; gp < brmd_pkg::NUM_PORTS; gp++) begin : g_port
         always_comb begin
            if (gp == 0) begin
               byte_addr[gp] = acc_word_in ? {acc_addr_in[7:1], 1'b0} : acc_addr_in;
               port_en[gp] = 1'b1;
            end else begin
               byte_addr[gp] = {acc_addr_in[7:1], 1'b1};
               port_en[gp] = acc_word_in;
            end
         end

         assign lane_hi[gp] = strap_q ? byte_addr[gp][0] : ~byte_addr[gp][0];
         assign wd_p[gp] = lane_hi[gp] ? acc_wdata_in[15:8] : acc_wdata_in[7:0];

         always_comb begin
            look[gp] = slot_lookup(byte_addr[gp], strap_q, sync);
            kind[gp] = glob_lookup(byte_addr[gp], strap_q);
            if (look[gp][5]) begin
               kind[gp] = brmd_pkg::SRC_MEM;
            end
         end

         assign bank.we[gp] = acc_req_in && acc_wr_in && port_en[gp]
                              && kind[gp] == brmd_pkg::SRC_MEM;
         assign bank.idx[gp] = {chan, look[gp][4:0]};
         assign bank.wd[gp] = wd_p[gp];
      end
   endgenerate

   brmd_bank_mem u_mem (
      .core_clk_in(core_clk_in),
      .rst_n_in(rst_n_in),
      .bank(bank)
   );

   always_comb begin
      car_wr = 1'b0;
      firmware_revision_code_wr = 1'b0;
      for (int p = 0; p < brmd_pkg::NUM_PORTS; p++) begin
         if (acc_req_in && acc_wr_in && port_en[p]) begin
            car_wr = car_wr || kind[p] == brmd_pkg::SRC_CAR;
            firmware_revision_code_wr = firmware_revision_code_wr || kind[p] == brmd_pkg::SRC_FIRMWARE_REVISION_CODE;
         end
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         car_q <= brmd_pkg::CAR_RESET;
         firmware_revision_code_q <= brmd_pkg::FIRMWARE_REVISION_CODE_RESET;
      end else begin
         for (int p = 0; p < brmd_pkg::NUM_PORTS; p++) begin
            if (acc_req_in && acc_wr_in && port_en[p]) begin
               if (kind[p] == brmd_pkg::SRC_CAR) begin
                  car_q <= wd_p[p];
               end
               if (kind[p] == brmd_pkg::SRC_FIRMWARE_REVISION_CODE) begin
                  firmware_revision_code_q <= wd_p[p];
               end
            end
         end
      end
   end

   // Mode shadow lets decode see each channel's protocol without a bank read
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         cmr_q[0] <= brmd_pkg::CMR_RESET;
         cmr_q[1] <= brmd_pkg::CMR_RESET;
      end else begin
         for (int p = 0; p < brmd_pkg::NUM_PORTS; p++) begin
            if (bank.we[p] && look[p][4:0] == brmd_pkg::SLOT_CMR) begin
               cmr_q[chan] <= wd_p[p];
            end
         end
      end
   end

   // Read stage one: bank data arrives alongside these
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         ack_a_q <= 1'b0;
         rd_a_q <= 1'b0;
         for (int p = 0; p < brmd_pkg::NUM_PORTS; p++) begin
            en_a_q[p] <= 1'b0;
            hi_a_q[p] <= 1'b0;
            src_a_q[p] <= brmd_pkg::SRC_NONE;
            glob_a_q[p] <= 8'h00;
         end
      end else begin
         ack_a_q <= acc_req_in;
         rd_a_q <= acc_req_in && !acc_wr_in;
         for (int p = 0; p < brmd_pkg::NUM_PORTS; p++) begin
            en_a_q[p] <= port_en[p];
            hi_a_q[p] <= lane_hi[p];
            src_a_q[p] <= kind[p];
            unique case (kind[p])
               brmd_pkg::SRC_FIRMWARE_REVISION_CODE: glob_a_q[p] <= firmware_revision_code_q;
               brmd_pkg::SRC_CAR: glob_a_q[p] <= car_q;
               brmd_pkg::SRC_NONE,
               brmd_pkg::SRC_MEM: glob_a_q[p] <= 8'h00;
            endcase
         end
      end
   end

   // Unmapped bytes read as zero; idle lane also reads zero
   always_comb begin
      rdata_d = 16'h0000;
      for (int p = 0; p < brmd_pkg::NUM_PORTS; p++) begin
         if (rd_a_q && en_a_q[p]) begin
            if (hi_a_q[p]) begin
               rdata_d[15:8] = (src_a_q[p] == brmd_pkg::SRC_MEM) ? bank.rd[p] : glob_a_q[p];
            end else begin
               rdata_d[7:0] = (src_a_q[p] == brmd_pkg::SRC_MEM) ? bank.rd[p] : glob_a_q[p];
            end
         end
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         rdata_q <= 16'h0000;
         ack_q <= 1'b0;
      end else begin
         rdata_q <= rdata_d;
         ack_q <= ack_a_q;
      end
   end

   assign ack_out = ack_q;
   assign rdata_out = rdata_q;
   assign map_le_out = strap_q;
   assign active_chan_out = chan;
   assign sync_mode_out = sync;

   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (!rst_n_in);

   a_lane_le_map: assert property (
      acc_req_in && !acc_wr_in && !acc_word_in && strap_q && acc_addr_in[0]
      |-> ##2 ack_out && rdata_out[7:0] == 8'h00)
      else $error("strap high odd byte leaked onto low lane");

   a_lane_be_map: assert property (
      acc_req_in && !acc_wr_in && !acc_word_in && !strap_q && acc_addr_in[0]
      |-> ##2 ack_out && rdata_out[15:8] == 8'h00)
      else $error("strap low odd byte leaked onto high lane");

   a_map_select: assert property (
      acc_req_in && !acc_word_in && acc_addr_in == brmd_pkg::OFS_CAR_LE
      |-> map_le_out == strap_q && (kind[0] == brmd_pkg::SRC_CAR) == strap_q)
      else $error("map does not follow strap");

   a_mode_offset: assert property (
      acc_req_in && acc_wr_in && !acc_word_in
      && acc_addr_in == (strap_q ? brmd_pkg::SLOT_OFS_LE[brmd_pkg::SLOT_CMR]
                                 : brmd_pkg::SLOT_OFS_BE[brmd_pkg::SLOT_CMR])
      |=> cmr_q[$past(chan)] == $past(wd_p[0]))
      else $error("mode register not at its offset");

   a_global_write: assert property (
      car_wr && !firmware_revision_code_wr |=> car_q == $past(wd_p[0]) || car_q == $past(wd_p[1]))
      else $error("channel select write lost");

   a_bank_channel: assert property (
      bank.we[0] |-> bank.idx[0][brmd_pkg::IDX_W-1] == active_chan_out)
      else $error("write reached wrong channel copy");

   a_select_hold: assert property (
      !car_wr |=> $stable(car_q))
      else $error("channel select changed without write");

   a_service_chan: assert property (
      svc_active_in |-> active_chan_out == svc_chan_in)
      else $error("service channel not applied");

   a_alias_mode: assert property (
      bank.we[0] && sync |-> !(bank.idx[0][4:0] inside {[brmd_pkg::ASYNC_FIRST:brmd_pkg::ASYNC_LAST]}))
      else $error("async alias written in sync mode");

   a_word_order: assert property (
      acc_req_in && acc_wr_in && acc_word_in && bank.we[0]
      |-> bank.wd[0] == (strap_q ? acc_wdata_in[7:0] : acc_wdata_in[15:8]))
      else $error("earlier byte on wrong lane");

   a_strap_static: assert property (
      $stable(strap_q))
      else $error("strap moved after reset");

   a_read_even_le: assert property (
      acc_req_in && !acc_wr_in && !acc_word_in && strap_q && !acc_addr_in[0]
      |-> ##2 ack_out && rdata_out[15:8] == 8'h00)
      else $error("strap high even byte leaked onto high lane");

   a_read_even_be: assert property (
      acc_req_in && !acc_wr_in && !acc_word_in && !strap_q && !acc_addr_in[0]
      |-> ##2 ack_out && rdata_out[7:0] == 8'h00)
      else $error("strap low even byte leaked onto low lane");

   a_write_lane_le: assert property (
      acc_req_in && acc_wr_in && !acc_word_in && strap_q && bank.we[0]
      |-> bank.wd[0] == (acc_addr_in[0] ? acc_wdata_in[15:8] : acc_wdata_in[7:0]))
      else $error("strap high write taken from wrong lane");

   a_write_lane_be: assert property (
      acc_req_in && acc_wr_in && !acc_word_in && !strap_q && bank.we[0]
      |-> bank.wd[0] == (acc_addr_in[0] ? acc_wdata_in[7:0] : acc_wdata_in[15:8]))
      else $error("strap low write taken from wrong lane");

   a_word_later: assert property (
      acc_req_in && acc_wr_in && acc_word_in && bank.we[1]
      |-> bank.wd[1] == (strap_q ? acc_wdata_in[15:8] : acc_wdata_in[7:0]))
      else $error("later byte on wrong lane");

   a_other_copy_0: assert property (
      acc_req_in && acc_wr_in && chan |=> $stable(cmr_q[0]))
      else $error("channel one write touched channel zero mode");

   a_other_copy_1: assert property (
      acc_req_in && acc_wr_in && !chan |=> $stable(cmr_q[1]))
      else $error("channel zero write touched channel one mode");

   a_service_bank: assert property (
      svc_active_in && bank.we[0] |-> bank.idx[0][brmd_pkg::IDX_W-1] == svc_chan_in)
      else $error("service write missed its channel");

   a_answer_time: assert property (
      acc_req_in |-> ##2 ack_out)
      else $error("access not answered in two cycles");

   a_no_stray_ack: assert property (
      !acc_req_in |-> ##2 !ack_out)
      else $error("answer without a request");

   c_word_read: cover property (acc_req_in && !acc_wr_in && acc_word_in ##2 ack_out);
   c_service_write: cover property (svc_active_in && bank.we[0]);
   c_sync_alias: cover property (sync && bank.we[0] && bank.idx[0][4:0] == 5'h0C);
   c_be_word_write: cover property (!strap_q && bank.we[0] && bank.we[1]);
   c_service_read: cover property (svc_active_in && acc_req_in && !acc_wr_in && chan != car_q[0]);
endmodule // brmd_top

/* File: brmd_pkg.sv */
package brmd_pkg;

   localparam int NUM_SLOTS = 22;
   localparam int SLOT_W = 5;
   localparam int IDX_W = 6;
   localparam int DEPTH = 64;
   localparam int NUM_PORTS = 2;

   // Per-channel slots; 8..11 are async-only and 12..15 sync-only aliases
   localparam logic [7:0] SLOT_OFS_LE [NUM_SLOTS] = '{
      8'h13, 8'h14, 8'h15, 8'h16, 8'h17, 8'h18, 8'h1B, 8'h04,
      8'h1C, 8'h1D, 8'h1E, 8'h1F, 8'h1C, 8'h1D, 8'h1E, 8'h1F,
      8'h20, 8'h21, 8'h22, 8'h23, 8'h2D, 8'hD4};
   localparam logic [7:0] SLOT_OFS_BE [NUM_SLOTS] = '{
      8'h10, 8'h17, 8'h16, 8'h15, 8'h14, 8'h1B, 8'h18, 8'h07,
      8'h1F, 8'h1E, 8'h1D, 8'h1C, 8'h1F, 8'h1E, 8'h1D, 8'h1C,
      8'h23, 8'h22, 8'h21, 8'h20, 8'h2E, 8'hD6};

   localparam logic [SLOT_W-1:0] SLOT_CMR = 5'h05;
   localparam int ASYNC_FIRST = 8;
   localparam int ASYNC_LAST = 11;
   localparam int SYNC_FIRST = 12;
   localparam int SYNC_LAST = 15;

   localparam logic [7:0] OFS_FIRMWARE_REVISION_CODE_LE = 8'h82;
   localparam logic [7:0] OFS_FIRMWARE_REVISION_CODE_BE = 8'h81;
   localparam logic [7:0] OFS_CAR_LE = 8'hEC;
   localparam logic [7:0] OFS_CAR_BE = 8'hEE;

   localparam int CMR_SYNC_BIT = 7;
   localparam int CAR_CHAN_BIT = 0;
   localparam logic [7:0] CAR_RESET = 8'h00;
   localparam logic [7:0] CMR_RESET = 8'h00;
   localparam logic [7:0] MEM_RESET = 8'h00;
   // Arbitrary neutral value
   localparam logic [7:0] FIRMWARE_REVISION_CODE_RESET = 8'h5A;

   typedef enum logic [1:0] {
      SRC_NONE,
      SRC_MEM,
      SRC_FIRMWARE_REVISION_CODE,
      SRC_CAR
   } brmd_src_t;

endpackage

/* File: brmd_bank_if.sv */
`timescale 1ns/1ns
interface brmd_bank_if;
   logic we [brmd_pkg::NUM_PORTS];
   logic [brmd_pkg::IDX_W-1:0] idx [brmd_pkg::NUM_PORTS];
   logic [7:0] wd [brmd_pkg::NUM_PORTS];
   logic [7:0] rd [brmd_pkg::NUM_PORTS];
   modport ctl (output we, output idx, output wd, input rd);
   modport mem (input we, input idx, input wd, output rd);
endinterface

/* File: brmd_bank_mem.sv */
`timescale 1ns/1ns
module brmd_bank_mem (
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   brmd_bank_if.mem bank
);
   logic [7:0] mem_q [brmd_pkg::DEPTH];

   // Cleared on reset so every channel copy has a defined value
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         for (int i = 0; i < brmd_pkg::DEPTH; i++) begin
            mem_q[i] <= brmd_pkg::MEM_RESET;
         end
      end else begin
         for (int p = 0; p < brmd_pkg::NUM_PORTS; p++) begin
            if (bank.we[p]) begin
               mem_q[bank.idx[p]] <= bank.wd[p];
            end
         end
      end
   end

   always_ff @(posedge core_clk_in) begin
      for (int p = 0; p < brmd_pkg::NUM_PORTS; p++) begin
         bank.rd[p] <= mem_q[bank.idx[p]];
      end
   end
endmodule // brmd_bank_mem

/* File: brmd_host_model.sv */
`timescale 1ns/1ns
module brmd_host_model (
   input wire logic clk_in,
   input wire logic ack_in,
   input wire logic [15:0] rdata_in,
   output logic req_out,
   output logic wr_out,
   output logic word_out,
   output logic [7:0] addr_out,
   output logic [15:0] wdata_out
);
   initial begin
      req_out = 1'b0;
      wr_out = 1'b0;
      word_out = 1'b0;
      addr_out = 8'h00;
      wdata_out = 16'h0000;
   end

   // One request pulse, then a bounded wait for the answer
   task automatic xfer(input logic wr, input logic word, input logic [7:0] a, input logic [15:0] d,
                       output logic [15:0] q, output logic ok);
      int n;
      n = 0;
      q = 16'h0000;
      ok = 1'b0;
      @(posedge clk_in);
      req_out <= 1'b1;
      wr_out <= wr;
      word_out <= word;
      addr_out <= a;
      wdata_out <= d;
      @(posedge clk_in);
      req_out <= 1'b0;
      // Idle bus shows the inverse so stale values cannot pass
      addr_out <= ~a;
      wdata_out <= ~d;
      while (n < 4 && !ok) begin
         @(posedge clk_in);
         n++;
         if (ack_in === 1'b1) begin
            ok = 1'b1;
            q = rdata_in;
         end
      end
   endtask
endmodule // brmd_host_model

/* File: tb.sv */
`timescale 1ns/1ns
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_fail++; \
   $display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end
module tb;
   logic clk = 1'b0, rst_n = 1'b0, strap = 1'b1, le = 1'b1, svc_act = 1'b0, svc_ch = 1'b0;
   logic req, wr, word, ack, map_le, act_ch, sync_m, ok;
   logic [7:0] addr;
   logic [15:0] wdata, rdata, q;
   int n_fail = 0, cmp_count = 0, cyc = 0;

   brmd_top brmd_top_i (.core_clk_in(clk), .rst_n_in(rst_n), .byte_order_in(strap), .acc_req_in(req),
      .acc_wr_in(wr), .acc_word_in(word), .acc_addr_in(addr), .acc_wdata_in(wdata), .svc_active_in(svc_act),
      .svc_chan_in(svc_ch), .ack_out(ack), .rdata_out(rdata), .map_le_out(map_le), .active_chan_out(act_ch),
      .sync_mode_out(sync_m));
   brmd_host_model brmd_host_model_i (.clk_in(clk), .ack_in(ack), .rdata_in(rdata), .req_out(req),
      .wr_out(wr), .word_out(word), .addr_out(addr), .wdata_out(wdata));

   initial begin
      forever #50 clk = ~clk;
   end

   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         n_fail++;
         $display("MISMATCH t=%0t run stalled", $time);
         end_of_test();
      end
   end

   task automatic end_of_test();
      $display("compares %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic do_reset(input logic s);
      @(posedge clk);
      strap <= s;
      le = s;
      rst_n <= 1'b0;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
   endtask

   // Byte write; the unused lane carries the inverse
   task automatic bwr(input logic [7:0] a, input logic [7:0] d);
      logic hi;
      hi = le ? a[0] : ~a[0];
      brmd_host_model_i.xfer(1'b1, 1'b0, a, hi ? {d, ~d} : {~d, d}, q, ok);
      `CHK(ok, 1'b1)
      // Writes answer with both lanes zero
      `CHK(q, 16'h0000)
   endtask

   task automatic bchk(input logic [7:0] a, input logic [7:0] e);
      logic hi;
      hi = le ? a[0] : ~a[0];
      brmd_host_model_i.xfer(1'b0, 1'b0, a, 16'h0000, q, ok);
      `CHK(ok, 1'b1)
      `CHK(q, hi ? {e, 8'h00} : {8'h00, e})
   endtask

   task automatic t_reset();
      bchk(8'hEC, 8'h00);
      bchk(8'h82, brmd_pkg::FIRMWARE_REVISION_CODE_RESET);
      bchk(8'h18, 8'h00);
      bchk(8'h00, 8'h00);
      $display("test reset done");
   endtask

   task automatic t_lanes();
      bwr(8'h13, 8'hA5);
      bchk(8'h13, 8'hA5);
      bwr(8'h04, 8'h3C);
      bchk(8'h04, 8'h3C);
      $display("test lanes done");
   endtask

   task automatic t_banks();
      bwr(8'hEC, 8'h01);
      `CHK(act_ch, 1'b1)
      bchk(8'h13, 8'h00);
      bwr(8'h13, 8'h5A);
      bwr(8'hEC, 8'h00);
      bchk(8'h13, 8'hA5);
      bwr(8'h82, 8'h77);
      bwr(8'hEC, 8'h01);
      bchk(8'h82, 8'h77);
      bchk(8'h13, 8'h5A);
      bchk(8'hEC, 8'h01);
      $display("test banks done");
   endtask

   task automatic t_svc();
      @(posedge clk);
      svc_act <= 1'b1;
      svc_ch <= 1'b0;
      bchk(8'h13, 8'hA5);
      `CHK(act_ch, 1'b0)
      // Channel select still names channel one, so this must land in channel zero
      bwr(8'h14, 8'h66);
      @(posedge clk);
      svc_ch <= 1'b1;
      bchk(8'h13, 8'h5A);
      bchk(8'h14, 8'h00);
      @(posedge clk);
      svc_act <= 1'b0;
      $display("test service done");
   endtask

   task automatic t_alias();
      bwr(8'h1C, 8'h11);
      bwr(8'h18, 8'h80);
      `CHK(sync_m, 1'b1)
      bchk(8'h1C, 8'h00);
      bwr(8'h1C, 8'h22);
      bwr(8'h18, 8'h00);
      bchk(8'h1C, 8'h11);
      $display("test alias done");
   endtask

   task automatic t_word();
      brmd_host_model_i.xfer(1'b1, 1'b1, 8'h1C, 16'hBBAA, q, ok);
      `CHK(ok, 1'b1)
      bchk(8'h1C, 8'hAA);
      bchk(8'h1D, 8'hBB);
      brmd_host_model_i.xfer(1'b0, 1'b1, 8'h1C, 16'h0000, q, ok);
      `CHK(ok, 1'b1)
      `CHK(q, 16'hBBAA)
      $display("test word done");
   endtask

   task automatic t_be();
      do_reset(1'b0);
      `CHK(map_le, 1'b0)
      bchk(8'hEE, 8'h00);
      bchk(8'h81, brmd_pkg::FIRMWARE_REVISION_CODE_RESET);
      bwr(8'hEE, 8'h01);
      `CHK(act_ch, 1'b1)
      brmd_host_model_i.xfer(1'b1, 1'b1, 8'h14, 16'h1234, q, ok);
      `CHK(ok, 1'b1)
      bchk(8'h14, 8'h12);
      bchk(8'h15, 8'h34);
      bwr(8'h1B, 8'h80);
      `CHK(sync_m, 1'b1)
      @(posedge clk);
      strap <= 1'b1;
      bchk(8'hEE, 8'h01);
      `CHK(map_le, 1'b0)
      $display("test big-endian map done");
   endtask

   initial begin
      do_reset(1'b1);
      t_reset();
      t_lanes();
      t_banks();
      t_svc();
      t_alias();
      t_word();
      t_be();
      end_of_test();
   end
endmodule // tb
